// ==== hw/serial_ctl_pkg.sv ====
// Shared constants and types for the serial control command slave
package serial_ctl_pkg;

    localparam int          NUM_CH         = 4;
    localparam int          MEM_DEPTH      = 256;
    localparam int          SCAN_BITS      = 2;
    localparam logic [7:0]  FAST_SCAN_CODE = 8'h02;
    localparam logic [2:0]  OP_WRITE       = 3'h1;
    localparam logic [2:0]  OP_READ        = 3'h3;
    localparam logic [2:0]  OP_WRITE_ALL   = 3'h5;
    localparam int          OP_LSB         = 0;
    localparam int          OP_MSB         = 2;
    localparam int          CKT_LSB        = 3;
    localparam int          CKT_MSB        = 4;
    localparam int          BANK_LSB       = 5;
    localparam int          BANK_MSB       = 7;
    localparam logic [2:0]  USER_BANK      = 3'h0;
    localparam logic [7:0]  SCAN_LOC       = 8'ha0;
    localparam logic [2:0]  BIT_FIRST      = 3'h0;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [2:0]  BIT_STEP       = 3'h1;
    localparam logic [7:0]  LEN_ONE        = 8'h01;
    localparam logic [7:0]  LEN_ZERO       = 8'h00;
    localparam logic [7:0]  ADDR_STEP      = 8'h01;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;

    // Synchronised pin levels
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
        logic mode_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, mode_n: 1'b1};

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        pins_t s3;
        pins_t filt;
    } sync_regs_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_LEN,
        ST_WDATA,
        ST_RWAIT,
        ST_REPLY,
        ST_DONE
    } cmd_state_t;

    typedef struct packed {
        cmd_state_t  st;
        pins_t       prev;
        logic        cs_lat;
        logic [2:0]  bitcnt;
        logic [7:0]  rx_sh;
        logic [2:0]  op;
        logic        fast;
        logic [1:0]  ch;
        logic [2:0]  bank;
        logic [7:0]  addr;
        logic [7:0]  remain;
        logic [7:0]  tx_sh;
        logic        sdo;
        logic        sdo_oe;
    } cmd_regs_t;

endpackage

// ==== hw/pin_sync3.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // Raw and filtered pins
    input  wire serial_ctl_pkg::pins_t pins_in,
    output serial_ctl_pkg::pins_t      pins_out
);
    import serial_ctl_pkg::*;

    sync_regs_t r_reg;
    sync_regs_t r_next;

    always_comb
    begin
        r_next      = r_reg;
        r_next.s1   = pins_in;
        r_next.s2   = r_reg.s1;
        r_next.s3   = r_reg.s2;
        // Level moves only once stages two and three agree
        r_next.filt = pins_t'((r_reg.s2 & r_reg.s3) | (r_reg.filt & (r_reg.s2 | r_reg.s3)));
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            r_reg <= '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, filt: PINS_IDLE};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign pins_out = r_reg.filt;

endmodule

// ==== hw/serial_cmd_slave.sv ====
// Serial control port command interpreter with per-channel control memory
//
// Contract
// RULE1: Serial output driven only in reply phase, gated by chip select alone.
// RULE2: Master waits after read request before reasserting chip select.
// RULE3: Master issues no new command before the pending reply is received.
// RULE4: Multi-byte commands walk consecutive locations in ascending order.
// RULE5: Write commands carry data and get no reply.
// RULE6: Read reply is data bytes only, no header or status.
// RULE7: Bits go LSB first; multibyte values low byte first.
// RULE8: Header selects memory bank; only bank 0 holds user controls.
// RULE9: Master leaves 244 ns between command frames.
// RULE10: At least 244 ns between fast-scan bytes.
// RULE11: Operation depends on clock transitions only, not rate.
// RULE12: Memory is byte wide; every read gets a reply.
// RULE13: Master keeps a single driver on the shared data line.
// RULE14: Master drops chip select after read request, reasserts for reply.
// RULE15: Reply excursion transmits and ignores input as command.
// RULE16: Master keeps chip select until all reply bytes are out.
// RULE17: Flow control only by splitting, clock pausing, or per-byte select.
// RULE18: Single byte 00000010 is fast scan, no address or length.
// RULE19: Fast-scan byte packs bits 1:0 of location 160 per channel.
// RULE20: Fast scan toggles chip select like a read.
// RULE21: Write-all stores into all four channels; others touch one channel.
// RULE22: Normal mode: select sampled on rising, input on falling edge.
// RULE23: Byte mode: select and input sampled on rising edge, eight bits.
// RULE24: Partial-byte select excursion aborts; next excursion is a new command.
// RULE25: Three-byte header: opcode, circuit, bank, start address, length.
`timescale 1ns/10ps
module serial_cmd_slave
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // Serial control pins
    input  wire logic cs_n,
    input  wire logic serial_shift_clock,
    input  wire logic serial_cmd_in,
    input  wire logic port_mode_select,
    // Serial reply pin, three-state
    output logic      reply_data_out,
    output logic      reply_data_oe
);
    import serial_ctl_pkg::*;

    localparam cmd_regs_t REGS_RST = '{st: ST_IDLE, prev: PINS_IDLE, default: '0};

    pins_t      raw_pins;
    pins_t      p;
    cmd_regs_t  r_reg;
    cmd_regs_t  r_next;
    logic [7:0] mem [NUM_CH][MEM_DEPTH];
    logic [7:0] scan_byte;
    logic [7:0] rd_byte;
    logic [7:0] rx;
    logic       cs_fall;
    logic       cs_rise;
    logic       byte_mode;
    logic       slot;
    logic       byte_done;
    logic       partial;
    logic       wr_en;
    logic       wr_all;

    assign raw_pins = '{cs_n: cs_n, sclk: serial_shift_clock, din: serial_cmd_in,
                        mode_n: port_mode_select};

    pin_sync3 u_sync
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .pins_in  (raw_pins),
        .pins_out (p)
    );

    // RULE19 fast scan packing
    always_comb
    begin
        scan_byte = BYTE_ZERO;
        for (int k = 0; k < NUM_CH; k++)
        begin
            scan_byte[SCAN_BITS*k +: SCAN_BITS] = mem[k][SCAN_LOC][SCAN_BITS-1:0];
        end
    end

    // RULE8 other banks read zero
    assign rd_byte = r_reg.fast ? scan_byte :
                     (r_reg.bank == USER_BANK) ? mem[r_reg.ch][r_reg.addr] : BYTE_ZERO;

    always_comb
    begin
        r_next    = r_reg;
        wr_en     = 1'b0;
        wr_all    = 1'b0;
        partial   = 1'b0;
        r_next.prev = p;
        byte_mode = ~p.mode_n;
        // RULE11 edges found from transitions only
        cs_fall   = r_reg.prev.cs_n & ~p.cs_n;
        cs_rise   = ~r_reg.prev.cs_n & p.cs_n;
        // RULE22 select latched on rising clock
        r_next.cs_lat = (~r_reg.prev.sclk & p.sclk) ? ~p.cs_n : r_reg.cs_lat;
        // RULE23 byte mode samples on rising edge
        slot = byte_mode ? (~r_reg.prev.sclk & p.sclk & ~p.cs_n)
                         : (r_reg.prev.sclk & ~p.sclk & r_reg.cs_lat);
        // RULE7 LSB arrives first
        rx        = {p.din, r_reg.rx_sh[7:1]};
        byte_done = slot && (r_reg.bitcnt == BIT_LAST);
        if (slot)
        begin
            r_next.bitcnt = r_reg.bitcnt + BIT_STEP;
            r_next.rx_sh  = rx;
            if (r_reg.st == ST_REPLY)
            begin
                r_next.tx_sh = {1'b0, r_reg.tx_sh[7:1]};
            end
        end
        if (byte_done)
        begin
            case (r_reg.st)
                ST_IDLE:
                begin
                    // RULE18 fast scan code
                    if (rx == FAST_SCAN_CODE)
                    begin
                        r_next.fast   = 1'b1;
                        r_next.remain = LEN_ONE;
                        r_next.st     = ST_RWAIT;
                    end
                    else
                    begin
                        // RULE25 header first byte
                        r_next.fast = 1'b0;
                        r_next.op   = rx[OP_MSB:OP_LSB];
                        r_next.ch   = rx[CKT_MSB:CKT_LSB];
                        r_next.bank = rx[BANK_MSB:BANK_LSB];
                        r_next.st   = ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    r_next.addr = rx;
                    r_next.st   = ST_LEN;
                end
                ST_LEN:
                begin
                    // RULE12 zero length still replies once
                    r_next.remain = (rx == LEN_ZERO) ? LEN_ONE : rx;
                    if (r_reg.op == OP_READ)
                    begin
                        r_next.st = ST_RWAIT;
                    end
                    else if ((r_reg.op == OP_WRITE) || (r_reg.op == OP_WRITE_ALL))
                    begin
                        r_next.st = ST_WDATA;
                    end
                    else
                    begin
                        r_next.st = ST_DONE;
                    end
                end
                ST_WDATA:
                begin
                    // RULE21 write one or all channels
                    wr_en  = (r_reg.bank == USER_BANK);
                    wr_all = wr_en && (r_reg.op == OP_WRITE_ALL);
                    // RULE4 ascending addresses
                    r_next.addr   = r_reg.addr + ADDR_STEP;
                    r_next.remain = r_reg.remain - LEN_ONE;
                    if (r_reg.remain == LEN_ONE)
                    begin
                        r_next.st = ST_DONE;
                    end
                end
                ST_REPLY:
                begin
                    r_next.remain = r_reg.remain - LEN_ONE;
                    if (r_reg.remain == LEN_ONE)
                    begin
                        r_next.st = ST_DONE;
                    end
                    else
                    begin
                        r_next.tx_sh = rd_byte;
                        r_next.addr  = r_reg.addr + ADDR_STEP;
                    end
                end
                default: ;
            endcase
        end
        if (cs_rise)
        begin
            // RULE24 partial byte aborts frame
            partial = (r_next.bitcnt != BIT_FIRST);
            if (partial)
            begin
                r_next.st     = ST_IDLE;
                r_next.bitcnt = BIT_FIRST;
            end
            // RULE10 RULE17 frame survives select gaps in byte mode; normal mode keeps only ST_RWAIT
            else if ((r_reg.st == ST_DONE) || (!byte_mode && (r_next.st != ST_RWAIT)))
            begin
                r_next.st = ST_IDLE;
            end
        end
        else if (cs_fall && (r_reg.st == ST_RWAIT))
        begin
            // RULE15 next excursion is the reply
            r_next.st     = ST_REPLY;
            r_next.tx_sh  = rd_byte;
            r_next.addr   = r_reg.addr + ADDR_STEP;
            r_next.bitcnt = BIT_FIRST;
        end
        // RULE1 drive only while selected in reply
        r_next.sdo    = r_next.tx_sh[0];
        r_next.sdo_oe = (r_next.st == ST_REPLY) && ~p.cs_n;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            r_reg <= REGS_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Control memory is not cleared; a reset leaves contents to be reloaded
    always_ff @(posedge sys_clk)
    begin
        for (int k = 0; k < NUM_CH; k++)
        begin
            if (wr_en && (wr_all || (k == int'(r_reg.ch))))
            begin
                mem[k][r_reg.addr] <= rx;
            end
        end
    end

    assign reply_data_out = r_reg.sdo;
    assign reply_data_oe  = r_reg.sdo_oe;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_reply_start;
        (r_reg.st == ST_RWAIT) && cs_fall && !cs_rise;
    endsequence
    sequence s_reply_shift;
        (r_reg.st == ST_REPLY) && slot && (r_reg.bitcnt != BIT_LAST);
    endsequence
    // Enable is registered, so it answers the select level one cycle late
    property p_oe_reply;
        reply_data_oe |-> (r_reg.st == ST_REPLY) && !$past(p.cs_n);
    endproperty
    a_oe_reply: assert property (p_oe_reply) else $error("output enabled outside reply"); // RULE1
    property p_abort;
        partial |=> (r_reg.st == ST_IDLE) && (r_reg.bitcnt == BIT_FIRST);
    endproperty
    a_abort: assert property (p_abort) else $error("partial byte did not abort"); // RULE24
    property p_write_silent;
        (r_reg.st == ST_WDATA) |-> !reply_data_oe;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write drove output"); // RULE5
    property p_fast;
        (r_reg.st == ST_IDLE) && byte_done && (rx == FAST_SCAN_CODE) && !cs_rise
            |=> (r_reg.st == ST_RWAIT) && r_reg.fast && (r_reg.remain == LEN_ONE);
    endproperty
    a_fast: assert property (p_fast) else $error("fast scan not recognised"); // RULE18
    property p_lsb_first;
        s_reply_shift |=> reply_data_out == $past(r_reg.tx_sh[1]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("reply bit order wrong"); // RULE7
    property p_first_bit;
        s_reply_start |=> (r_reg.st == ST_REPLY) && (reply_data_out == $past(rd_byte[0]));
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("reply not data byte"); // RULE6
    property p_no_cmd_in_reply;
        (r_reg.st == ST_REPLY) |-> !wr_en;
    endproperty
    a_no_cmd_in_reply: assert property (p_no_cmd_in_reply) else $error("write in reply"); // RULE15
    property p_ascend;
        wr_en |=> r_reg.addr == $past(r_reg.addr) + ADDR_STEP;
    endproperty
    a_ascend: assert property (p_ascend) else $error("address did not ascend"); // RULE4
    property p_all_chan;
        wr_all |-> (r_reg.op == OP_WRITE_ALL) && (r_reg.bank == USER_BANK);
    endproperty
    a_all_chan: assert property (p_all_chan) else $error("bad write-all"); // RULE21
    property p_read_reply;
        (r_reg.st == ST_LEN) && byte_done && (r_reg.op == OP_READ) && !cs_rise
            |=> (r_reg.st == ST_RWAIT) && (r_reg.remain != LEN_ZERO);
    endproperty
    a_read_reply: assert property (p_read_reply) else $error("read gave no reply"); // RULE12

endmodule

// ==== sim/ctl_master_model.sv ====
// Behavioural master of the serial control port
`timescale 1ns/10ps
module ctl_master_model
(
    // Clock
    input  wire logic sys_clk,
    // Pins towards the slave
    output logic      cs_n,
    output logic      serial_shift_clock,
    output logic      serial_cmd_in,
    output logic      port_mode_select,
    // reply pin is only listened to
    input  wire logic reply_data_out,
    input  wire logic reply_data_oe
);
    int   gap_at = -1;
    logic in_reply = 1'b0;

    initial
    begin
        cs_n = 1'b1;
        serial_shift_clock = 1'b0;
        serial_cmd_in = 1'b0;
        port_mode_select = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic set_mode(input logic m);
        @(posedge sys_clk);
        port_mode_select <= m;
        wait_clk(8);
    endtask

    // Released data line shows the inverse, never a held value
    task automatic sel(input logic lvl);
        @(posedge sys_clk);
        cs_n <= lvl;
        serial_cmd_in <= lvl ? ~serial_cmd_in : serial_cmd_in;
        wait_clk(8);
    endtask

    // bit set while clock low, reply sampled before the shift edge
    // Link clock period is eight system clocks; a released reply pin reads inverted
    task automatic bit_io(input logic b, output logic r);
        wait_clk(1);
        serial_cmd_in <= b;
        wait_clk(3);
        if (!port_mode_select)
            r = reply_data_oe ? reply_data_out : ~reply_data_out;
        serial_shift_clock <= 1'b1;
        wait_clk(4);
        if (port_mode_select)
            r = reply_data_oe ? reply_data_out : ~reply_data_out;
        serial_shift_clock <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 0; i < 8; i++)
        begin
            bit_io(tx[i], rx[i]);
            // pause with the clock held low
            if (i == gap_at)
                wait_clk(20);
        end
    endtask

    // one excursion per frame, or per byte in byte mode
    task automatic excursion(input logic [7:0] q[$], output logic [7:0] got[$]);
        logic [7:0] rx;
        got = {};
        if (port_mode_select)
            sel(1'b0);
        foreach (q[i])
        begin
            if (!port_mode_select)
                sel(1'b0);
            xfer(q[i], rx);
            got.push_back(rx);
            if (!port_mode_select)
                sel(1'b1);
        end
        if (port_mode_select)
            sel(1'b1);
        // at least 244 ns before the next frame
        wait_clk(30);
    endtask

    // request, then a reply excursion of n bytes
    task automatic cmd(input logic [7:0] req[$], input int n, output logic [7:0] rep[$]);
        logic [7:0] fill[$];
        excursion(req, rep);
        if (n > 0)
        begin
            // Reply excursion carries a write that must be ignored, well-formed only when n is at least 4
            for (int i = 0; i < n; i++)
                fill.push_back(8'(32'hee01_1001 >> (8 * (i % 4))));
            in_reply = 1'b1;
            excursion(fill, rep);
            in_reply = 1'b0;
        end
    endtask
endmodule

// ==== sim/test_serial_control_command_slave.sv ====
// Self-checking bench for the serial control command slave
`timescale 1ns/10ps
module test_serial_control_command_slave;
    import serial_ctl_pkg::*;

    logic       sys_clk;
    logic       srst;
    logic       cs_n;
    logic       sclk;
    logic       din;
    logic       mode_sel;
    logic       rdo;
    logic       roe;
    int         fail_count = 0;
    int         tests_run = 0;
    logic [7:0] got[$];

    serial_cmd_slave i_dut
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .cs_n(cs_n),
        .serial_shift_clock(sclk),
        .serial_cmd_in(din),
        .port_mode_select(mode_sel),
        .reply_data_out(rdo),
        .reply_data_oe(roe)
    );

    ctl_master_model i_master
    (
        .sys_clk(sys_clk),
        .cs_n(cs_n),
        .serial_shift_clock(sclk),
        .serial_cmd_in(din),
        .port_mode_select(mode_sel),
        .reply_data_out(rdo),
        .reply_data_oe(roe)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reply pin may only be driven inside a reply excursion
    always @(posedge sys_clk)
        if (!srst && roe === 1'b1 && !i_master.in_reply)
            check(8'h01, 8'h00);

    function automatic logic [7:0] hdr(logic [2:0] op, logic [1:0] ckt, logic [2:0] bank);
        return {bank, ckt, op};
    endfunction

    task automatic wr(input logic [2:0] op, input logic [1:0] ckt, input logic [2:0] bank,
                      input logic [7:0] addr, input logic [7:0] d[$]);
        logic [7:0] q[$];
        q = {hdr(op, ckt, bank), addr, 8'(d.size())};
        q = {q, d};
        i_master.cmd(q, 0, got);
    endtask

    task automatic rd_check(input logic [1:0] ckt, input logic [2:0] bank,
                            input logic [7:0] addr, input logic [7:0] exp[$]);
        logic [7:0] q[$];
        q = {hdr(OP_READ, ckt, bank), addr, 8'(exp.size())};
        i_master.cmd(q, exp.size(), got);
        foreach (exp[i])
            check(got[i], exp[i]);
    endtask

    task automatic t_write_read();
        wr(OP_WRITE, 2'h1, USER_BANK, 8'h10, '{8'h11, 8'h22, 8'h33});
        rd_check(2'h1, USER_BANK, 8'h10, '{8'h11, 8'h22, 8'h33});
        rd_check(2'h1, USER_BANK, 8'h11, '{8'h22});
        wr(OP_WRITE, 2'h0, USER_BANK, 8'h10, '{8'h5a, 8'ha5, 8'h3c, 8'hc3});
        rd_check(2'h0, USER_BANK, 8'h10, '{8'h5a, 8'ha5, 8'h3c, 8'hc3});
        rd_check(2'h0, USER_BANK, 8'h10, '{8'h5a});
        $display("test write_read done");
    endtask

    task automatic t_write_all();
        wr(OP_WRITE_ALL, 2'h2, USER_BANK, 8'h20, '{8'h5a, 8'hc3});
        for (int c = 0; c < NUM_CH; c++)
            rd_check(2'(c), USER_BANK, 8'h20, '{8'h5a, 8'hc3});
        wr(OP_WRITE, 2'h3, USER_BANK, 8'h20, '{8'h0f});
        rd_check(2'h2, USER_BANK, 8'h20, '{8'h5a});
        rd_check(2'h3, USER_BANK, 8'h20, '{8'h0f});
        wr(OP_WRITE, 2'h3, 3'h1, 8'h20, '{8'hff});
        rd_check(2'h3, USER_BANK, 8'h20, '{8'h0f});
        rd_check(2'h3, 3'h1, 8'h20, '{BYTE_ZERO});
        $display("test write_all done");
    endtask

    task automatic t_fast_scan();
        logic [7:0] scan[4] = '{8'h00, 8'hfd, 8'h32, 8'hcf};
        logic [7:0] exp;
        exp = {scan[3][1:0], scan[2][1:0], scan[1][1:0], scan[0][1:0]};
        for (int c = 0; c < NUM_CH; c++)
            wr(OP_WRITE, 2'(c), USER_BANK, SCAN_LOC, '{scan[c]});
        for (int m = 1; m >= 0; m--)
        begin
            i_master.set_mode(1'(m));
            i_master.cmd('{FAST_SCAN_CODE}, 1, got);
            check(got[0], exp);
        end
        $display("test fast_scan done");
    endtask

    task automatic t_byte_mode();
        i_master.set_mode(1'b0);
        wr(OP_WRITE, 2'h2, USER_BANK, 8'h40, '{8'h96, 8'h69});
        rd_check(2'h2, USER_BANK, 8'h40, '{8'h96, 8'h69});
        i_master.set_mode(1'b1);
        $display("test byte_mode done");
    endtask

    task automatic t_recover();
        logic r;
        i_master.sel(1'b0);
        repeat (5) i_master.bit_io(1'b1, r);
        i_master.sel(1'b1);
        i_master.wait_clk(30);
        i_master.gap_at = 3;
        wr(OP_WRITE, 2'h1, USER_BANK, 8'h50, '{8'ha7});
        rd_check(2'h1, USER_BANK, 8'h50, '{8'ha7});
        i_master.gap_at = -1;
        // Unknown opcode: rest of frame ignored, memory untouched
        wr(3'h2, 2'h1, USER_BANK, 8'h50, '{8'h00});
        rd_check(2'h1, USER_BANK, 8'h50, '{8'ha7});
        $display("test recover done");
    endtask

    initial
    begin
        i_master.wait_clk(40000);
        fail_count++;
        wrap_up();
    end

    initial
    begin
        srst = 1'b1;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        i_master.wait_clk(6);
        t_write_read();
        t_write_all();
        t_fast_scan();
        t_byte_mode();
        t_recover();
        wrap_up();
    end
endmodule
